// ---- hdl/sync_select_map.vh ----
// Register offsets, field layouts, codes and reset values of the sync select bank.
`ifndef SYNC_SELECT_MAP_VH
`define SYNC_SELECT_MAP_VH

`define ADDR_W                 8
`define DATA_W                 16
`define ZERO16                 16'h0000

`define OFF_OUTPUT_GAIN_TRIG   8'h21
`define OFF_SYNC_PIN_TRIG      8'h22
`define OFF_TONE_GEN_TRIG      8'h23
`define OFF_CAP_ONE_TRIG       8'h24
`define OFF_CAP_TWO_TRIG       8'h25
`define OFF_S1_CANCELER_CNT    8'h30
`define OFF_S1_DETECT_THR      8'h31
`define OFF_S1_TARGET_THR      8'h32
`define OFF_S1_PULSE_DELAY     8'h33
`define OFF_S2_CANCELER_CNT    8'h38
`define OFF_TIMER_TRIG         8'h1c
`define OFF_ALLOC_TRIG         8'h1f
`define OFF_COEF_TRIG          8'h1e
`define OFF_SW_EVENT           8'h0a
`define OFF_OUT_SCALE0         8'h50
`define OFF_OUT_BIAS_LAST      8'h55
`define OFF_STATUS             8'h5f

`define SEL_W                  3
`define SEL_NEVER              3'h0
`define SEL_SW                 3'h1
`define SEL_TIMER              3'h2
`define SEL_SYNC_A             3'h3
`define SEL_SYNC_B             3'h4
`define SEL_ALWAYS             3'h5

`define SW_BIT_COEF            5
`define SW_BIT_ALLOC           6
`define SW_BIT_TONE            10
`define TIMER_REPEAT_BIT       15
`define COUNT_W                4
`define DELAY_W                8
`define COUNT_MAX              4'h8

`endif

// ---- hdl/sync_select_bank.v ----
// Trigger source selection and peak cancel stage configuration registers.
`timescale 1ns/1ps
`include "sync_select_map.vh"

// Function
// - Three-bit select codes: never, software, timer, pin A, pin B, always; 6,7 invalid.
// - All six output scale and bias values move to datapath together on trigger.
// - With select always, any output scale or bias write takes effect immediately.
// - Sync output pin follows event chosen by the sync pin select.
// - Tone generator starts only on its selected trigger event.
// - Software write of bit 10 triggers only the tone generator.
// - Capture RAM one enables on its selected trigger event.
// - Capture RAM two enables on its own selected trigger event.
// - Both capture RAMs may start together on one event.
// - Canceler counts are four bits, 0 to 8; upper bits reserved. The bank stores and applies 9 to 15 unchanged.
// - Written canceler counts apply only on allocation trigger.
// - Detect threshold is a 16-bit squared magnitude above which peaks are cut.
// - Target threshold holds the full 16-bit squared level for cut peaks.
// - A peak is cut only if a canceler is free.
// - Pulse delay is eight bits, valid 5 to 255; upper bits reserved.
// - Pulse delay reaches delay block only on coefficient trigger.
// - All registers clear to zero at reset, except the timer state, which resets to idle (3'b001).
// - Bit 6 triggers only allocation, bit 5 only coefficient transfer.
// - Timer fires once, or repeatedly when its repeat bit is set.
module sync_select_bank #(
  parameter TIMER_PERIOD = 16'h0400
) (
  // Clock and reset
  input  wire                 i_clk,
  input  wire                 i_rst,
  // Register port
  input  wire [`ADDR_W-1:0]   i_addr,
  input  wire [`DATA_W-1:0]   i_wdata,
  input  wire                 i_wr,
  input  wire                 i_rd,
  output reg  [`DATA_W-1:0]   o_rdata,
  // Sync pins
  input  wire                 i_sync_a,
  input  wire                 i_sync_b,
  output reg                  o_sync_out,
  // Triggered functions and direct threshold outputs
  output reg                  o_out_load,
  output reg  [`DATA_W*6-1:0] o_out_values,
  output reg                  o_tone_start,
  output reg                  o_tone_running,
  output reg                  o_cap_one_start,
  output reg                  o_cap_one_enabled,
  output reg                  o_cap_two_start,
  output reg                  o_cap_two_enabled,
  output reg                  o_alloc_load,
  output reg  [`COUNT_W-1:0]  o_s1_count,
  output reg  [`COUNT_W-1:0]  o_s2_count,
  output reg                  o_coef_load,
  output reg  [`DELAY_W-1:0]  o_s1_delay,
  output wire [`DATA_W-1:0]   o_s1_detect_thr,
  output wire [`DATA_W-1:0]   o_s1_target_thr,
  // Peak cut decision
  input  wire                 i_peak_valid,
  input  wire [`DATA_W-1:0]   i_peak_mag_sq,
  input  wire                 i_canceler_free,
  output reg                  o_peak_cut
);

  localparam [2:0] TMR_IDLE = 3'b001;
  localparam [2:0] TMR_RUN  = 3'b010;
  localparam [2:0] TMR_DONE = 3'b100;

  reg [`DATA_W-1:0]  out_gain_sel_reg;
  reg [`DATA_W-1:0]  pin_sel_reg;
  reg [`DATA_W-1:0]  tone_sel_reg;
  reg [`DATA_W-1:0]  cap_one_sel_reg;
  reg [`DATA_W-1:0]  cap_two_sel_reg;
  reg [`DATA_W-1:0]  timer_sel_reg;
  reg [`DATA_W-1:0]  alloc_sel_reg;
  reg [`DATA_W-1:0]  coef_sel_reg;
  reg [`COUNT_W-1:0] s1_count_reg;
  reg [`COUNT_W-1:0] s2_count_reg;
  reg [`DATA_W-1:0]  s1_detect_reg;
  reg [`DATA_W-1:0]  s1_target_reg;
  reg [`DELAY_W-1:0] s1_delay_reg;
  reg [`DATA_W-1:0]  out_shadow_reg [0:5];
  reg [2:0]          sync_a_reg;
  reg [2:0]          sync_b_reg;
  reg                sw_tone_reg;
  reg                sw_alloc_reg;
  reg                sw_coef_reg;
  reg                out_write_reg;
  reg [2:0]          tmr_state_reg;
  reg [15:0]         tmr_count_reg;
  reg                tmr_event_reg;
  integer            k;

  // A pin event is one cycle: second and third stage agree on a new high.
  // Only the second and third stages decide, so a metastable first stage never
  // reaches the edge logic.
  wire a_event = sync_a_reg[1] & sync_a_reg[2];
  wire b_event = sync_b_reg[1] & sync_b_reg[2];
  reg  a_seen_reg;
  reg  b_seen_reg;
  wire a_pulse = a_event & ~a_seen_reg;
  wire b_pulse = b_event & ~b_seen_reg;

  // Shared select decode; an always source is a strobe on every cycle.
  function trig;
    input [`SEL_W-1:0] sel;
    input              sw;
    begin
      case (sel)
        `SEL_SW:     trig = sw;
        `SEL_TIMER:  trig = tmr_event_reg;
        `SEL_SYNC_A: trig = a_pulse;
        `SEL_SYNC_B: trig = b_pulse;
        `SEL_ALWAYS: trig = 1'b1;
        default:     trig = 1'b0;
      endcase
    end
  endfunction

  wire in_out_bank = (i_addr >= `OFF_OUT_SCALE0) && (i_addr <= `OFF_OUT_BIAS_LAST);
  // The shadow bank starts on an eight-word boundary, so the low offset bits index it.
  wire [`ADDR_W-1:0] out_off = i_addr - `OFF_OUT_SCALE0;
  wire [2:0] out_idx = out_off[2:0];

  wire out_trig   = (out_gain_sel_reg[`SEL_W-1:0] == `SEL_ALWAYS) ? out_write_reg :
                    trig(out_gain_sel_reg[`SEL_W-1:0], 1'b0);
  wire pin_trig   = trig(pin_sel_reg[`SEL_W-1:0], 1'b0);
  wire tone_trig  = trig(tone_sel_reg[`SEL_W-1:0], sw_tone_reg);
  wire one_trig   = trig(cap_one_sel_reg[`SEL_W-1:0], 1'b0);
  wire two_trig   = trig(cap_two_sel_reg[`SEL_W-1:0], 1'b0);
  wire alloc_trig = trig(alloc_sel_reg[`SEL_W-1:0], sw_alloc_reg);
  wire coef_trig  = trig(coef_sel_reg[`SEL_W-1:0], sw_coef_reg);
  wire tmr_start  = trig(timer_sel_reg[`SEL_W-1:0], 1'b0) &
                    (timer_sel_reg[`SEL_W-1:0] != `SEL_TIMER);

  // Pin synchronisers and edge memory.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_a_reg <= 3'h0;
      sync_b_reg <= 3'h0;
      a_seen_reg <= 1'b0;
      b_seen_reg <= 1'b0;
    end else begin
      sync_a_reg <= {sync_a_reg[1:0], i_sync_a};
      sync_b_reg <= {sync_b_reg[1:0], i_sync_b};
      if (sync_a_reg[1] == sync_a_reg[2]) begin
        a_seen_reg <= sync_a_reg[2];
      end
      if (sync_b_reg[1] == sync_b_reg[2]) begin
        b_seen_reg <= sync_b_reg[2];
      end
    end
  end

  // Register writes and software event strobes.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      out_gain_sel_reg <= `ZERO16;
      pin_sel_reg      <= `ZERO16;
      tone_sel_reg     <= `ZERO16;
      cap_one_sel_reg  <= `ZERO16;
      cap_two_sel_reg  <= `ZERO16;
      timer_sel_reg    <= `ZERO16;
      alloc_sel_reg    <= `ZERO16;
      coef_sel_reg     <= `ZERO16;
      s1_count_reg     <= {`COUNT_W{1'b0}};
      s2_count_reg     <= {`COUNT_W{1'b0}};
      s1_detect_reg    <= `ZERO16;
      s1_target_reg    <= `ZERO16;
      s1_delay_reg     <= {`DELAY_W{1'b0}};
      sw_tone_reg      <= 1'b0;
      sw_alloc_reg     <= 1'b0;
      sw_coef_reg      <= 1'b0;
      out_write_reg    <= 1'b0;
      for (k = 0; k < 6; k = k + 1) begin
        out_shadow_reg[k] <= `ZERO16;
      end
    end else begin
      sw_tone_reg   <= i_wr && (i_addr == `OFF_SW_EVENT) && i_wdata[`SW_BIT_TONE];
      sw_alloc_reg  <= i_wr && (i_addr == `OFF_SW_EVENT) && i_wdata[`SW_BIT_ALLOC];
      sw_coef_reg   <= i_wr && (i_addr == `OFF_SW_EVENT) && i_wdata[`SW_BIT_COEF];
      out_write_reg <= i_wr && in_out_bank;
      if (i_wr) begin
        if (i_addr == `OFF_OUTPUT_GAIN_TRIG) begin
          out_gain_sel_reg <= {13'h0000, i_wdata[`SEL_W-1:0]};
        end else if (i_addr == `OFF_SYNC_PIN_TRIG) begin
          pin_sel_reg <= {13'h0000, i_wdata[`SEL_W-1:0]};
        end else if (i_addr == `OFF_TONE_GEN_TRIG) begin
          tone_sel_reg <= {13'h0000, i_wdata[`SEL_W-1:0]};
        end else if (i_addr == `OFF_CAP_ONE_TRIG) begin
          cap_one_sel_reg <= {13'h0000, i_wdata[`SEL_W-1:0]};
        end else if (i_addr == `OFF_CAP_TWO_TRIG) begin
          cap_two_sel_reg <= {13'h0000, i_wdata[`SEL_W-1:0]};
        end else if (i_addr == `OFF_TIMER_TRIG) begin
          timer_sel_reg <= {i_wdata[`TIMER_REPEAT_BIT], 12'h000, i_wdata[`SEL_W-1:0]};
        end else if (i_addr == `OFF_ALLOC_TRIG) begin
          alloc_sel_reg <= {13'h0000, i_wdata[`SEL_W-1:0]};
        end else if (i_addr == `OFF_COEF_TRIG) begin
          coef_sel_reg <= {13'h0000, i_wdata[`SEL_W-1:0]};
        end else if (i_addr == `OFF_S1_CANCELER_CNT) begin
          s1_count_reg <= i_wdata[`COUNT_W-1:0];
        end else if (i_addr == `OFF_S2_CANCELER_CNT) begin
          s2_count_reg <= i_wdata[`COUNT_W-1:0];
        end else if (i_addr == `OFF_S1_DETECT_THR) begin
          s1_detect_reg <= i_wdata;
        end else if (i_addr == `OFF_S1_TARGET_THR) begin
          s1_target_reg <= i_wdata;
        end else if (i_addr == `OFF_S1_PULSE_DELAY) begin
          s1_delay_reg <= i_wdata[`DELAY_W-1:0];
        end else if (in_out_bank) begin
          out_shadow_reg[out_idx] <= i_wdata;
        end
      end
    end
  end

  // Timer: started by its own select, runs once or repeats.
  // A one-shot timer parks in its done state until software rewrites its select,
  // so a stray pin edge cannot fire it a second time.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tmr_state_reg <= TMR_IDLE;
      tmr_count_reg <= 16'h0000;
      tmr_event_reg <= 1'b0;
    end else begin
      tmr_event_reg <= 1'b0;
      case (tmr_state_reg)
        TMR_IDLE: begin
          if (tmr_start) begin
            tmr_count_reg <= TIMER_PERIOD;
            tmr_state_reg <= TMR_RUN;
          end
        end
        TMR_RUN: begin
          if (tmr_count_reg <= 16'h0001) begin
            tmr_event_reg <= 1'b1;
            if (timer_sel_reg[`TIMER_REPEAT_BIT]) begin
              tmr_count_reg <= TIMER_PERIOD;
            end else begin
              tmr_state_reg <= TMR_DONE;
            end
          end else begin
            tmr_count_reg <= tmr_count_reg - 16'h0001;
          end
        end
        TMR_DONE: begin
          if (i_wr && (i_addr == `OFF_TIMER_TRIG)) begin
            tmr_state_reg <= TMR_IDLE;
          end
        end
        default: tmr_state_reg <= TMR_IDLE;
      endcase
    end
  end

  assign o_s1_detect_thr = s1_detect_reg;
  assign o_s1_target_thr = s1_target_reg;

  // Applied values and one-cycle strobes.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sync_out        <= 1'b0;
      o_out_load        <= 1'b0;
      o_out_values      <= {`DATA_W*6{1'b0}};
      o_tone_start      <= 1'b0;
      o_tone_running    <= 1'b0;
      o_cap_one_start   <= 1'b0;
      o_cap_one_enabled <= 1'b0;
      o_cap_two_start   <= 1'b0;
      o_cap_two_enabled <= 1'b0;
      o_alloc_load      <= 1'b0;
      o_s1_count        <= {`COUNT_W{1'b0}};
      o_s2_count        <= {`COUNT_W{1'b0}};
      o_coef_load       <= 1'b0;
      o_s1_delay        <= {`DELAY_W{1'b0}};
      o_peak_cut        <= 1'b0;
    end else begin
      o_sync_out      <= pin_trig;
      o_out_load      <= out_trig;
      o_tone_start    <= tone_trig;
      o_cap_one_start <= one_trig;
      o_cap_two_start <= two_trig;
      o_alloc_load    <= alloc_trig;
      o_coef_load     <= coef_trig;
      if (out_trig) begin
        o_out_values <= {out_shadow_reg[5], out_shadow_reg[4], out_shadow_reg[3],
                         out_shadow_reg[2], out_shadow_reg[1], out_shadow_reg[0]};
      end
      if (tone_trig) begin
        o_tone_running <= 1'b1;
      end
      if (one_trig) begin
        o_cap_one_enabled <= 1'b1;
      end
      if (two_trig) begin
        o_cap_two_enabled <= 1'b1;
      end
      if (alloc_trig) begin
        o_s1_count <= s1_count_reg;
        o_s2_count <= s2_count_reg;
      end
      if (coef_trig) begin
        o_s1_delay <= s1_delay_reg;
      end
      // Cut only over the threshold and only while a canceler is free.
      o_peak_cut <= i_peak_valid && (i_peak_mag_sq > s1_detect_reg) &&
                    i_canceler_free && (o_s1_count != {`COUNT_W{1'b0}});
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= `ZERO16;
    end else if (!i_rd) begin
      o_rdata <= `ZERO16;
    end else if (i_addr == `OFF_OUTPUT_GAIN_TRIG) begin
      o_rdata <= out_gain_sel_reg;
    end else if (i_addr == `OFF_SYNC_PIN_TRIG) begin
      o_rdata <= pin_sel_reg;
    end else if (i_addr == `OFF_TONE_GEN_TRIG) begin
      o_rdata <= tone_sel_reg;
    end else if (i_addr == `OFF_CAP_ONE_TRIG) begin
      o_rdata <= cap_one_sel_reg;
    end else if (i_addr == `OFF_CAP_TWO_TRIG) begin
      o_rdata <= cap_two_sel_reg;
    end else if (i_addr == `OFF_TIMER_TRIG) begin
      o_rdata <= timer_sel_reg;
    end else if (i_addr == `OFF_ALLOC_TRIG) begin
      o_rdata <= alloc_sel_reg;
    end else if (i_addr == `OFF_COEF_TRIG) begin
      o_rdata <= coef_sel_reg;
    end else if (i_addr == `OFF_S1_CANCELER_CNT) begin
      o_rdata <= {12'h000, s1_count_reg};
    end else if (i_addr == `OFF_S2_CANCELER_CNT) begin
      o_rdata <= {12'h000, s2_count_reg};
    end else if (i_addr == `OFF_S1_DETECT_THR) begin
      o_rdata <= s1_detect_reg;
    end else if (i_addr == `OFF_S1_TARGET_THR) begin
      o_rdata <= s1_target_reg;
    end else if (i_addr == `OFF_S1_PULSE_DELAY) begin
      o_rdata <= {8'h00, s1_delay_reg};
    end else if (in_out_bank) begin
      o_rdata <= out_shadow_reg[out_idx];
    end else if (i_addr == `OFF_STATUS) begin
      o_rdata <= {9'h000, tmr_state_reg, o_cap_two_enabled, o_cap_one_enabled,
                  o_tone_running, o_peak_cut};
    end else begin
      o_rdata <= `ZERO16;
    end
  end

endmodule // sync_select_bank

// ---- verification/host_model.sv ----
// Host processor model that drives the register port.
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire        i_clk,
  // Register port
  output reg  [7:0]  o_addr,
  output reg  [15:0] o_wdata,
  output reg         o_wr,
  output reg         o_rd,
  input  wire [15:0] i_rdata
);
  reg [15:0] rd_val;
  initial begin
    o_addr = 8'h00;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
    rd_val = 16'h0000;
  end
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
    end
  endtask
  // Read data are taken at the edge after the strobe, the only cycle they stand.
  task rd(input [7:0] a);
    begin
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      @(posedge i_clk);
      rd_val = i_rdata;
    end
  endtask
endmodule // host_model

// ---- verification/sync_select_bank_asserts.sv ----
// Concurrent checks on the ports of the sync select bank.
`timescale 1ns/1ps
module sync_select_checker (
  input wire        i_clk,
  input wire        i_rst,
  input wire [7:0]  i_addr,
  input wire        i_wr,
  input wire        i_peak_valid,
  input wire [15:0] i_peak_mag_sq,
  input wire        i_canceler_free,
  input wire        o_peak_cut,
  input wire [3:0]  o_s1_count,
  input wire [3:0]  o_s2_count,
  input wire        o_alloc_load,
  input wire [7:0]  o_s1_delay,
  input wire        o_coef_load,
  input wire [95:0] o_out_values,
  input wire        o_out_load,
  input wire [15:0] o_s1_detect_thr,
  input wire [15:0] o_s1_target_thr,
  input wire        o_tone_start,
  input wire        o_tone_running,
  input wire        o_cap_one_start,
  input wire        o_cap_one_enabled,
  input wire        o_cap_two_start,
  input wire        o_cap_two_enabled
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire peak_hit = i_peak_valid && (i_peak_mag_sq > o_s1_detect_thr) && i_canceler_free &&
                  (o_s1_count != 4'h0);
  peak_cut_a: assert property (peak_hit |=> o_peak_cut)
    else $error("over-threshold peak was not cut");
  free_only_a: assert property (!peak_hit |=> !o_peak_cut)
    else $error("peak cut without cause");
  count_hold_a: assert property ($changed({o_s1_count, o_s2_count}) |-> o_alloc_load)
    else $error("counts changed without allocation strobe");
  delay_hold_a: assert property ($changed(o_s1_delay) |-> o_coef_load)
    else $error("delay changed without coefficient strobe");
  out_group_a: assert property ($changed(o_out_values) |-> o_out_load)
    else $error("output values changed without load strobe");
  target_write_a: assert property ($changed(o_s1_target_thr) |-> $past(i_wr) && $past(i_addr) == 8'h32)
    else $error("target threshold changed without a write");
  tone_run_a: assert property (o_tone_start |-> ##[0:1] o_tone_running)
    else $error("tone generator did not start");
  cap_one_on_a: assert property (o_cap_one_start |-> ##[0:1] o_cap_one_enabled)
    else $error("capture ram one not enabled");
  cap_two_on_a: assert property (o_cap_two_start |-> ##[0:1] o_cap_two_enabled)
    else $error("capture ram two not enabled");
  cover property (o_alloc_load);
  cover property (o_cap_one_start && o_cap_two_start);
  cover property (o_peak_cut);
endmodule // sync_select_checker
bind sync_select_bank sync_select_checker chk (.i_clk, .i_rst, .i_addr, .i_wr, .i_peak_valid,
  .i_peak_mag_sq, .i_canceler_free, .o_peak_cut, .o_s1_count, .o_s2_count, .o_alloc_load,
  .o_s1_delay, .o_coef_load, .o_out_values, .o_out_load, .o_s1_detect_thr, .o_s1_target_thr,
  .o_tone_start, .o_tone_running, .o_cap_one_start, .o_cap_one_enabled, .o_cap_two_start,
  .o_cap_two_enabled);

// ---- verification/testbench.sv ----
// Self-checking bench for the sync select bank.
`timescale 1ns/1ps
module testbench;
  reg         clk, rst, sync_a, sync_b, pk_valid, pk_free;
  reg  [15:0] pk_mag;
  wire [7:0]  addr;
  wire [15:0] wdata, rdata, det_thr, tgt_thr;
  wire        wr, rd, sync_out, out_load, tone_start, tone_run, cap1_start, cap1_en;
  wire        cap2_start, cap2_en, alloc_load, coef_load, peak_cut;
  wire [95:0] out_vals;
  wire [3:0]  s1_cnt, s2_cnt;
  wire [7:0]  s1_dly;
  reg  [7:0]  seen;
  reg         clr;
  reg  [22:0] rows [0:3];
  integer     n_sync, error_cnt, n_tests, i;
  localparam [79:0] REGS = 80'h21222324253031323338;
  always #2.5 clk = ~clk;
  host_model host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
    .i_rdata(rdata));
  sync_select_bank #(.TIMER_PERIOD(16'h0004)) DUT (.i_clk(clk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sync_a(sync_a),
    .i_sync_b(sync_b), .o_sync_out(sync_out), .o_out_load(out_load), .o_out_values(out_vals),
    .o_tone_start(tone_start), .o_tone_running(tone_run), .o_cap_one_start(cap1_start),
    .o_cap_one_enabled(cap1_en), .o_cap_two_start(cap2_start), .o_cap_two_enabled(cap2_en),
    .o_alloc_load(alloc_load), .o_s1_count(s1_cnt), .o_s2_count(s2_cnt),
    .o_coef_load(coef_load), .o_s1_delay(s1_dly), .o_s1_detect_thr(det_thr),
    .o_s1_target_thr(tgt_thr), .i_peak_valid(pk_valid), .i_peak_mag_sq(pk_mag),
    .i_canceler_free(pk_free), .o_peak_cut(peak_cut));
  always @(posedge clk) begin
    if (clr) begin
      seen <= 8'h00;
      n_sync <= 0;
    end else begin
      seen <= seen | {cap1_start & cap2_start, sync_out, out_load, cap2_start, cap1_start,
                      tone_start, alloc_load, coef_load};
      if (sync_out === 1'b1) n_sync <= n_sync + 1;
    end
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task rdchk(input [7:0] a, input [15:0] exp);
    begin
      host.rd(a);
      chk(host.rd_val, exp);
    end
  endtask
  // Optional register write, then a pin pulse long enough for the synchronisers.
  task ev(input [7:0] a, input [15:0] d, input [1:0] p);
    begin
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      if (a != 8'h00) host.wr(a, d);
      @(posedge clk);
      {sync_b, sync_a} <= p;
      repeat (3) @(posedge clk);
      {sync_b, sync_a} <= 2'b00;
      repeat (10) @(posedge clk);
    end
  endtask
  task peak(input [15:0] mag, input free, input exp);
    begin
      @(posedge clk);
      pk_valid <= 1'b1;
      pk_mag <= mag;
      pk_free <= free;
      @(posedge clk);
      pk_valid <= 1'b0;
      @(negedge clk);
      chk({15'h0, peak_cut}, {15'h0, exp});
    end
  endtask
  task end_of_test;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt = error_cnt + 1;
    $display("BAD %0t timeout", $time);
    end_of_test;
  end
  initial begin
    {clk, rst, clr, sync_a, sync_b, pk_valid, pk_free, pk_mag} = {4'b0110, 19'h0};
    {error_cnt, n_tests} = 0;
    rows[0] = {16'h0400, 7'h04};
    rows[1] = {16'h0040, 7'h02};
    rows[2] = {16'h0020, 7'h01};
    rows[3] = {16'h0000, 7'h00};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    clr <= 1'b0;
    for (i = 0; i < 10; i = i + 1) rdchk(REGS[79-8*i -: 8], 16'h0000);
    rdchk(8'h7f, 16'h0000);
    chk({s1_cnt, s2_cnt, s1_dly}, 16'h0000);
    host.wr(8'h21, 16'hfffe);
    rdchk(8'h21, 16'h0006);
    host.wr(8'h30, 16'h0008);
    rdchk(8'h30, 16'h0008);
    host.wr(8'h30, 16'h0003);
    host.wr(8'h38, 16'h0005);
    host.wr(8'h33, 16'h12ff);
    rdchk(8'h33, 16'h00ff);
    host.wr(8'h32, 16'habcd);
    rdchk(8'h32, 16'habcd);
    chk(tgt_thr, 16'habcd);
    host.wr(8'h23, 16'h0001);
    host.wr(8'h1f, 16'h0001);
    host.wr(8'h1e, 16'h0001);
    chk({s1_cnt, s2_cnt, s1_dly}, 16'h0000);
    for (i = 0; i < 4; i = i + 1) begin
      ev(8'h0a, rows[i][22:7], 2'b00);
      chk({8'h0, seen}, {9'h0, rows[i][6:0]});
    end
    chk({s1_cnt, s2_cnt, s1_dly}, 16'h35ff);
    host.wr(8'h1f, 16'h0007);
    host.wr(8'h30, 16'h0001);
    ev(8'h0a, 16'h0040, 2'b00);
    chk({4'h0, seen, s1_cnt}, 16'h0003);
    host.wr(8'h21, 16'h0005);
    ev(8'h50, 16'h1234, 2'b00);
    chk({15'h0, seen[5]}, 16'h0001);
    chk(out_vals[15:0], 16'h1234);
    host.wr(8'h21, 16'h0003);
    host.wr(8'h24, 16'h0003);
    host.wr(8'h25, 16'h0003);
    host.wr(8'h22, 16'h0004);
    ev(8'h51, 16'h5678, 2'b00);
    chk(out_vals[31:16], 16'h0000);
    ev(8'h00, 16'h0000, 2'b01);
    chk({8'h0, seen}, 16'h00b8);
    chk(out_vals[31:16], 16'h5678);
    chk(out_vals[15:0], 16'h1234);
    chk({13'h0, tone_run, cap1_en, cap2_en}, 16'h0007);
    ev(8'h00, 16'h0000, 2'b10);
    chk({8'h0, seen}, 16'h0040);
    host.wr(8'h22, 16'h0002);
    ev(8'h1c, 16'h0003, 2'b01);
    repeat (30) @(posedge clk);
    chk(n_sync[15:0], 16'h0001);
    ev(8'h1c, 16'h8003, 2'b01);
    repeat (30) @(posedge clk);
    chk({15'h0, n_sync > 5}, 16'h0001);
    host.wr(8'h31, 16'h1000);
    @(negedge clk);
    chk(det_thr, 16'h1000);
    peak(16'h1001, 1'b1, 1'b1);
    peak(16'h1000, 1'b1, 1'b0);
    peak(16'hffff, 1'b0, 1'b0);
    // A second reset in mid-run must clear applied values and sticky levels.
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({s1_cnt, s2_cnt, s1_dly}, 16'h0000);
    chk({13'h0, tone_run, cap1_en, cap2_en}, 16'h0000);
    rdchk(8'h33, 16'h0000);
    end_of_test;
  end
endmodule // testbench
